// File: hdl/supply_monitor_cfg.svh
`ifndef SUPPLY_MONITOR_CFG_SVH
`define SUPPLY_MONITOR_CFG_SVH
// Register byte addresses
`define SM_CTRL_ADDR 12'h000
`define SM_IRQ_ADDR 12'h004
`define SM_ADDR_W 12
// Control register fields
`define SM_WIDTH_HI 7
`define SM_WIDTH_LO 6
`define SM_OUTFLAG_BIT 5
`define SM_ENABLE_BIT 4
`define SM_SPARE_BIT 3
`define SM_THR_HI 2
`define SM_THR_LO 0
`define SM_CTRL_RESET 8'h00
`define SM_CTRL_WMASK 8'hd7
// Interrupt register fields
`define SM_IRQ_FLAG_BIT 2
`define SM_IRQ_EN_BIT 1
`define SM_GIE_BIT 0
// Threshold codes
`define SM_THR_3V3 3'h5
`define SM_THR_3V6 3'h6
`define SM_THR_4V0 3'h7
// Width codes and slow-tick counts (upper bound of each range)
`define SM_W_CODE_34 2'h1
`define SM_W_CODE_78 2'h2
`define SM_W_TICKS_12 4'h2
`define SM_W_TICKS_34 4'h4
`define SM_W_TICKS_78 4'h8
// Slow oscillator period: 32 us at 100 MHz
`define SM_SLOW_PERIOD_NS 32000
`define SM_SYS_PERIOD_NS 10
`define SM_SLOW_DIV (`SM_SLOW_PERIOD_NS / `SM_SYS_PERIOD_NS)
`define SM_DIV_W 12
// Flag run-length counter; covers the widest filter of 8 periods
`define SM_RUN_W 15
// Bus responses
`define SM_RESP_OKAY 2'h0
`define SM_RESP_SLVERR 2'h2
`endif

// File: hdl/supply_monitor_pkg.sv
package supply_monitor_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_TIMING = 2'b10
    } filt_state_t;
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } bus_out_t;
endpackage : supply_monitor_pkg

// File: hdl/supply_monitor.sv
// Functional notes
// - Enable bit 4 powers the detector
// - Threshold codes 101/110/111 select 3.3/3.6/4.0
// - Output flag bit 5 shows supply low
// - Width codes give 1-2, 3-4, 7-8 ticks
// - Detector forced off in sleep
// - Interrupt only after flag held for width, or when software sets the request flag
// - Filtered event sets the request flag
// - Filtered event wakes device from idle only while the request flag is clear
// - Bit 3 reads zero; output flag read-only
`timescale 1ns/1ps
`default_nettype none
`include "supply_monitor_cfg.svh"
module supply_monitor (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic [31:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [31:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    input wire logic i_comp_low,
    input wire logic i_sleep,
    input wire logic i_idle,
    output logic o_detector_power,
    output logic [2:0] o_threshold_code,
    output logic o_irq,
    output logic o_wake
);

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        supply_monitor_pkg::bus_out_t bus;
        logic [31:0] awaddr;
        logic aw_held;
        logic [7:0] wdata;
        logic w_held;
        logic w_strb0;
        logic [7:0] ctrl;
        logic irq_flag;
        logic irq_en;
        logic gie;
        logic comp_s1;
        logic comp_s2;
        logic out_flag;
        logic [`SM_DIV_W-1:0] div_cnt;
        logic [3:0] tick_cnt;
        logic [`SM_RUN_W-1:0] high_run;
        supply_monitor_pkg::filt_state_t fst;
        logic power;
        logic irq;
        logic wake;
    } state_t;

    state_t state_reg;
    state_t state_next;

    // Slow-tick count for a width code; codes 00 and 11 share one range
    function automatic logic [3:0] width_ticks(input logic [1:0] code);
        if (code == `SM_W_CODE_34) begin
            return `SM_W_TICKS_34;
        end else if (code == `SM_W_CODE_78) begin
            return `SM_W_TICKS_78;
        end
        return `SM_W_TICKS_12;
    endfunction : width_ticks

    // Only the three documented codes are valid thresholds
    function automatic logic thr_valid(input logic [2:0] code);
        return (code == `SM_THR_3V3) || (code == `SM_THR_3V6) ||
            (code == `SM_THR_4V0);
    endfunction : thr_valid

    function automatic logic addr_hit(input logic [31:0] a, input logic [11:0] off);
        return (a[`SM_ADDR_W-1:2] == off[`SM_ADDR_W-1:2]) && (a[31:`SM_ADDR_W] == '0);
    endfunction : addr_hit

    ////////////////////////////////////////////////////////////////////////
    logic do_write;
    logic tick;
    logic active;
    logic event_hit;
    logic [7:0] ctrl_view;
    logic [7:0] irq_view;

    // Next-state logic: bus slave, control, filter, interrupt
    always_comb begin
        state_next = state_reg;
        // Synchronise the asynchronous comparator output
        state_next.comp_s1 = i_comp_low;
        state_next.comp_s2 = state_reg.comp_s1;
        active = state_reg.ctrl[`SM_ENABLE_BIT] && !i_sleep;
        state_next.power = active;
        // Comparator only trusted with a valid threshold; low when off
        state_next.out_flag = active && state_reg.comp_s2 &&
            thr_valid(state_reg.ctrl[`SM_THR_HI:`SM_THR_LO]);
        // Slow oscillator period from a divider; runs only while active
        tick = 1'b0;
        if (!active || state_reg.div_cnt == `SM_DIV_W'(`SM_SLOW_DIV - 1)) begin
            state_next.div_cnt = '0;
            tick = active;
        end else begin
            state_next.div_cnt = state_reg.div_cnt + 1'b1;
        end
        // Width filter: first tick may be partial, giving n-1..n periods
        event_hit = 1'b0;
        unique case (state_reg.fst)
            supply_monitor_pkg::ST_IDLE: begin
                state_next.tick_cnt = '0;
                if (state_reg.out_flag) begin
                    state_next.fst = supply_monitor_pkg::ST_TIMING;
                end
            end
            supply_monitor_pkg::ST_TIMING: begin
                if (!state_reg.out_flag) begin
                    state_next.fst = supply_monitor_pkg::ST_IDLE;
                end else if (tick) begin
                    if (state_reg.tick_cnt + 4'h1 >=
                        width_ticks(state_reg.ctrl[`SM_WIDTH_HI:`SM_WIDTH_LO])) begin
                        event_hit = 1'b1;
                        state_next.fst = supply_monitor_pkg::ST_IDLE;
                    end else begin
                        state_next.tick_cnt = state_reg.tick_cnt + 4'h1;
                    end
                end
            end
            default: begin
                state_next.fst = supply_monitor_pkg::ST_IDLE;
            end
        endcase
        // Consecutive flag-high cycles, saturating; feeds the width check only
        if (!state_reg.out_flag) begin
            state_next.high_run = '0;
        end else if (state_reg.high_run != '1) begin
            state_next.high_run = state_reg.high_run + 1'b1;
        end
        // Address and data channels accepted in either order
        if (i_awvalid && state_reg.bus.awready) begin
            state_next.awaddr = i_awaddr;
            state_next.aw_held = 1'b1;
            state_next.bus.awready = 1'b0;
        end
        if (i_wvalid && state_reg.bus.wready) begin
            state_next.wdata = i_wdata[7:0];
            state_next.w_strb0 = i_wstrb[0];
            state_next.w_held = 1'b1;
            state_next.bus.wready = 1'b0;
        end
        do_write = state_reg.aw_held && state_reg.w_held && !state_reg.bus.bvalid;
        if (do_write) begin
            state_next.aw_held = 1'b0;
            state_next.w_held = 1'b0;
            state_next.bus.bvalid = 1'b1;
            state_next.bus.bresp = `SM_RESP_SLVERR;
            if (addr_hit(state_reg.awaddr, `SM_CTRL_ADDR)) begin
                state_next.bus.bresp = `SM_RESP_OKAY;
                if (state_reg.w_strb0) begin
                    // Output flag and bit 3 are not writable
                    state_next.ctrl = state_reg.wdata & `SM_CTRL_WMASK;
                end
            end else if (addr_hit(state_reg.awaddr, `SM_IRQ_ADDR)) begin
                state_next.bus.bresp = `SM_RESP_OKAY;
                if (state_reg.w_strb0) begin
                    // Software may set the flag too, to suppress idle wake
                    state_next.irq_flag = state_reg.wdata[`SM_IRQ_FLAG_BIT];
                    state_next.irq_en = state_reg.wdata[`SM_IRQ_EN_BIT];
                    state_next.gie = state_reg.wdata[`SM_GIE_BIT];
                end
            end
        end
        if (state_reg.bus.bvalid && i_bready) begin
            state_next.bus.bvalid = 1'b0;
            state_next.bus.awready = 1'b1;
            state_next.bus.wready = 1'b1;
        end
        // Set wins over a same-cycle software clear
        if (event_hit) begin
            state_next.irq_flag = 1'b1;
        end
        // Read channel: one cycle from address to data
        ctrl_view = state_reg.ctrl;
        ctrl_view[`SM_OUTFLAG_BIT] = state_reg.out_flag;
        irq_view = '0;
        irq_view[`SM_IRQ_FLAG_BIT] = state_reg.irq_flag;
        irq_view[`SM_IRQ_EN_BIT] = state_reg.irq_en;
        irq_view[`SM_GIE_BIT] = state_reg.gie;
        if (i_arvalid && state_reg.bus.arready) begin
            state_next.bus.arready = 1'b0;
            state_next.bus.rvalid = 1'b1;
            state_next.bus.rresp = `SM_RESP_SLVERR;
            state_next.bus.rdata = '0;
            if (addr_hit(i_araddr, `SM_CTRL_ADDR)) begin
                state_next.bus.rresp = `SM_RESP_OKAY;
                state_next.bus.rdata = {24'h000000, ctrl_view};
            end else if (addr_hit(i_araddr, `SM_IRQ_ADDR)) begin
                state_next.bus.rresp = `SM_RESP_OKAY;
                state_next.bus.rdata = {24'h000000, irq_view};
            end
        end
        if (state_reg.bus.rvalid && i_rready) begin
            state_next.bus.rvalid = 1'b0;
            state_next.bus.arready = 1'b1;
        end
        // Processor interrupt needs both enables; idle wake needs no enable, only the filtered event with the flag clear
        state_next.irq = state_next.irq_flag && state_next.irq_en &&
            state_next.gie;
        // A flag that is already set (software preset) suppresses the idle wake
        state_next.wake = i_idle && event_hit && !state_reg.irq_flag;
    end

    // State register
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= '0;
            state_reg.bus.awready <= 1'b1;
            state_reg.bus.wready <= 1'b1;
            state_reg.bus.arready <= 1'b1;
            state_reg.ctrl <= `SM_CTRL_RESET;
            state_reg.fst <= supply_monitor_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from flip-flops
    assign o_awready = state_reg.bus.awready;
    assign o_wready = state_reg.bus.wready;
    assign o_bvalid = state_reg.bus.bvalid;
    assign o_bresp = state_reg.bus.bresp;
    assign o_arready = state_reg.bus.arready;
    assign o_rvalid = state_reg.bus.rvalid;
    assign o_rresp = state_reg.bus.rresp;
    assign o_rdata = state_reg.bus.rdata;
    assign o_detector_power = state_reg.power;
    assign o_threshold_code = state_reg.ctrl[`SM_THR_HI:`SM_THR_LO];
    assign o_irq = state_reg.irq;
    assign o_wake = state_reg.wake;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    power_gate_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        state_reg.power |-> $past(state_reg.ctrl[`SM_ENABLE_BIT]))
        else $error("detector powered while disabled");
    sleep_off_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        i_sleep |=> !state_reg.power)
        else $error("detector powered in sleep");
    flag_thr_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        state_reg.out_flag |-> $past(thr_valid(state_reg.ctrl[`SM_THR_HI:`SM_THR_LO])))
        else $error("output flag with reserved threshold");
    flag_ro_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        !state_reg.ctrl[`SM_OUTFLAG_BIT] && !state_reg.ctrl[`SM_SPARE_BIT])
        else $error("read-only bits stored");
    // Flag and power register the same enable term, so the flag is never high while power is off
    flag_low_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        !state_reg.power |-> !state_reg.out_flag)
        else $error("output flag set while off");
    // Judged on the flag's run length, not the tick count, so a bad filter shows
    filter_min_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        event_hit |-> int'(state_reg.high_run) >=
            (int'(width_ticks(state_reg.ctrl[`SM_WIDTH_HI:`SM_WIDTH_LO])) - 1) * `SM_SLOW_DIV)
        else $error("event before minimum width");
    restart_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (state_reg.fst == supply_monitor_pkg::ST_TIMING && !state_reg.out_flag)
        |=> state_reg.fst == supply_monitor_pkg::ST_IDLE && !event_hit)
        else $error("filter not restarted");
    flag_set_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        event_hit |=> state_reg.irq_flag ##1 o_irq == (state_reg.irq_en && state_reg.gie))
        else $error("event did not set flag");
    irq_gate_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        o_irq |-> state_reg.irq_flag && state_reg.irq_en && state_reg.gie)
        else $error("interrupt without enables");
    wake_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (event_hit && i_idle && !state_reg.irq_flag) |=> o_wake)
        else $error("no wake from idle");
    preset_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (event_hit && state_reg.irq_flag) |=> !o_wake)
        else $error("wake despite preset flag");
    wake_pulse_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        o_wake |=> !o_wake)
        else $error("wake longer than one cycle");
    // Bus answers stand until the master takes them
    resp_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (o_bvalid && !i_bready) |=> o_bvalid && $stable(o_bresp))
        else $error("write response dropped early");
    read_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (o_rvalid && !i_rready) |=> o_rvalid && $stable(o_rdata) && $stable(o_rresp))
        else $error("read data dropped early");
    event_c: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) event_hit);
    abort_c: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        state_reg.fst == supply_monitor_pkg::ST_TIMING && !state_reg.out_flag);
    irq_c: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) o_irq);
    wake_c: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) o_wake);
    preset_c: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        event_hit && state_reg.irq_flag);

endmodule : supply_monitor
`default_nettype wire

// File: verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "supply_monitor_cfg.svh"
module testbench;
    localparam int DIV = `SM_SLOW_DIV;
    localparam logic [31:0] CTRL = 32'(`SM_CTRL_ADDR);
    localparam logic [31:0] IRQR = 32'(`SM_IRQ_ADDR);
    logic i_sys_clk, i_rst_n, awvalid, wvalid, bready, arvalid, rready;
    logic comp_low, sleep, idle, awready, wready, bvalid, arready, rvalid;
    logic power, irq, wake, woke;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [2:0] thr;
    int errors, num_checks, cnt;
    ////////////////////////////////////////////////////////////////////////////////
    supply_monitor supply_monitor_i (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
        .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
        .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
        .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
        .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
        .i_rready(rready), .i_comp_low(comp_low), .i_sleep(sleep), .i_idle(idle),
        .o_detector_power(power), .o_threshold_code(thr), .o_irq(irq), .o_wake(wake));
    // 100 MHz system clock
    initial begin
        i_sys_clk = 1'b0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge i_sys_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge i_sys_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, bresp});
    endtask : wr
    // Read data and response are taken at the rvalid edge
    task automatic rd(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] er,
                      input string name);
        @(posedge i_sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge i_sys_clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk(name, exp, rdata);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
    endtask : rd
    // Delay from comparator rise to interrupt must fall inside the filter window
    task automatic wait_irq(input int lo, input int hi);
        cnt = 0;
        woke = 1'b0;
        do begin
            @(posedge i_sys_clk);
            cnt++;
            if (wake === 1'b1) woke = 1'b1;
        end while (irq !== 1'b1 && cnt < hi);
        chk("irq_delay_in_window", 1, cnt >= lo && cnt < hi);
    endtask : wait_irq
    task automatic finish_test;
        if (errors == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test
    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog above the roughly 81k cycles the tests need
    initial begin
        repeat (95000) @(posedge i_sys_clk);
        errors++;
        finish_test();
    end
    // Main sequence
    initial begin
        {i_rst_n, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {comp_low, sleep, idle} = 3'h0;
        {awaddr, wdata, araddr} = {32'h0, 32'h0, 32'h0};
        wstrb = 4'hf;
        repeat (16) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        chk("power_rst", 0, power);
        rd(CTRL, 32'h00, `SM_RESP_OKAY, "ctrl_rst");
        rd(IRQR, 32'h00, `SM_RESP_OKAY, "irq_rst");
        wr(CTRL, 32'hff, `SM_RESP_OKAY);
        rd(CTRL, 32'hd7, `SM_RESP_OKAY, "ctrl_ro_bits");
        chk("power_on", 1, power);
        // Byte lane 0 disabled: accepted, no change
        wstrb <= 4'he;
        wr(CTRL, 32'h00, `SM_RESP_OKAY);
        wstrb <= 4'hf;
        rd(CTRL, 32'hd7, `SM_RESP_OKAY, "ctrl_strb_off");
        wr(32'h100, 32'h5, `SM_RESP_SLVERR);
        rd(32'h100, 32'h0, `SM_RESP_SLVERR, "unmapped");
        // Every threshold code, reserved ones must never report low supply
        comp_low <= 1'b1;
        for (int c = 0; c < 8; c++) begin
            wr(CTRL, 32'h10 | c, `SM_RESP_OKAY);
            repeat (6) @(posedge i_sys_clk);
            chk("thr_code", c, thr);
            rd(CTRL, 32'h10 | c | ((c >= 5) ? 32'h20 : 32'h0), `SM_RESP_OKAY, "low_flag");
        end
        sleep <= 1'b1;
        repeat (5) @(posedge i_sys_clk);
        chk("power_sleep", 0, power);
        rd(CTRL, 32'h17, `SM_RESP_OKAY, "flag_sleep");
        sleep <= 1'b0;
        wr(CTRL, 32'h07, `SM_RESP_OKAY);
        repeat (5) @(posedge i_sys_clk);
        chk("power_off", 0, power);
        rd(CTRL, 32'h07, `SM_RESP_OKAY, "flag_off");
        comp_low <= 1'b0;
        // Each width code in idle: filtered event sets flag, interrupt and wake
        wr(IRQR, 32'h3, `SM_RESP_OKAY);
        idle <= 1'b1;
        for (int w = 0; w < 4; w++) begin
            cnt = (w == 2) ? 8 : (w == 1) ? 4 : 2;
            wr(CTRL, (w << 6) | 32'h15, `SM_RESP_OKAY);
            comp_low <= 1'b1;
            wait_irq((cnt - 1) * DIV, cnt * DIV + 20);
            chk("wake", 1, woke);
            rd(IRQR, 32'h7, `SM_RESP_OKAY, "irq_flag");
            comp_low <= 1'b0;
            wr(IRQR, 32'h3, `SM_RESP_OKAY);
            repeat (3) @(posedge i_sys_clk);
            chk("irq_clear", 0, irq);
        end
        // Short low dip must restart the 4-period filter
        wr(CTRL, 32'h55, `SM_RESP_OKAY);
        comp_low <= 1'b1;
        repeat (2 * DIV) @(posedge i_sys_clk);
        comp_low <= 1'b0;
        repeat (10) @(posedge i_sys_clk);
        comp_low <= 1'b1;
        repeat (2 * DIV) @(posedge i_sys_clk);
        chk("early_irq", 0, irq);
        wait_irq(DIV, 2 * DIV + 20);
        comp_low <= 1'b0;
        // Software-set flag gated by local and global enables
        for (int e = 0; e < 4; e++) begin
            wr(IRQR, 32'h4 | e, `SM_RESP_OKAY);
            repeat (3) @(posedge i_sys_clk);
            chk("irq_gate", e == 3, irq);
        end
        // Flag preset during idle keeps a new event from waking the core
        wr(CTRL, 32'h15, `SM_RESP_OKAY);
        woke = 1'b0;
        comp_low <= 1'b1;
        repeat (3 * DIV) begin
            @(posedge i_sys_clk);
            if (wake === 1'b1) woke = 1'b1;
        end
        chk("preset_no_wake", 0, woke);
        finish_test();
    end
endmodule : testbench
`default_nettype wire
